// [shared/pso_pkg.sv]
// Constants and types for the status output block.
// Assumes a 10 MHz clock; timing counted in ms ticks.
package pso_pkg;

   // Clock and tick
   localparam int unsigned CLK_HZ        = 10_000_000;
   localparam int unsigned MS_PER_S      = 1000;
   localparam int unsigned CYC_PER_MS    = CLK_HZ / MS_PER_S;

   // Indicator pattern times, in ms
   localparam int unsigned SLOW_ON_MS    = 1000;
   localparam int unsigned SLOW_OFF_MS   = 1000;
   localparam int unsigned RAPID_ON_MS   = 250;
   localparam int unsigned RAPID_OFF_MS  = 250;
   localparam int unsigned VOLT_ON_MS    = 125;
   localparam int unsigned VOLT_OFF_MS   = 875;
   localparam int unsigned DATA_BLINK_MS = 25;

   // Debounce and output times, in minutes, seconds and ms
   localparam int unsigned MS_PER_MIN    = 60_000;
   localparam int unsigned IP_FAIL_MIN   = 2;
   localparam int unsigned WL_FAIL_MIN   = 15;
   localparam int unsigned PSTN_FAIL_MIN = 15;
   localparam int unsigned NOACK_S       = 80;
   localparam int unsigned RPS_MIN_S     = 1;
   localparam int unsigned QUERY_PULSE_MS = 1000;
   localparam int unsigned MAINS_DEF_MIN = 7;

   localparam int unsigned TMR_W         = 20;
   localparam logic [TMR_W-1:0] IP_FAIL_TICKS   = TMR_W'(IP_FAIL_MIN * MS_PER_MIN);
   localparam logic [TMR_W-1:0] WL_FAIL_TICKS   = TMR_W'(WL_FAIL_MIN * MS_PER_MIN);
   localparam logic [TMR_W-1:0] PSTN_FAIL_TICKS = TMR_W'(PSTN_FAIL_MIN * MS_PER_MIN);
   localparam logic [TMR_W-1:0] NOACK_TICKS     = TMR_W'(NOACK_S * MS_PER_S);
   localparam logic [TMR_W-1:0] RPS_MIN_TICKS   = TMR_W'(RPS_MIN_S * MS_PER_S);
   localparam logic [TMR_W-1:0] QUERY_TICKS     = TMR_W'(QUERY_PULSE_MS);
   localparam logic [TMR_W-1:0] MIN_TICKS       = TMR_W'(MS_PER_MIN);

   // Path establishment states
   localparam logic [1:0] PATH_DOWN      = 2'h0;
   localparam logic [1:0] PATH_ADDRESS   = 2'h1;
   localparam logic [1:0] PATH_UP        = 2'h2;

   // Fail-output mode selector values
   localparam logic [2:0] FMODE_QUERY    = 3'h1;
   localparam logic [2:0] FMODE_LINE     = 3'h2;
   localparam logic [2:0] FMODE_SPLIT    = 3'h4;

   // Telemetry commands
   localparam logic       TELEM_ID_LOW   = 1'h0;
   localparam logic       TELEM_ID_HIGH  = 1'h1;
   localparam logic [7:0] TELEM_DATA_SET = 8'h01;

   localparam logic [2:0] MAINS_DELAY_RST = 3'h7;

   typedef enum logic [2:0] {DOT_OFF, DOT_ON, DOT_SLOW, DOT_RAPID, DOT_VOLT} pso_dot_mode_t;

endpackage

// [shared/pso_dot_if.sv]
// Carrier to one dot pattern generator.
// Assumes both ends share the system clock.
interface pso_dot_if;
   pso_pkg::pso_dot_mode_t mode;
   logic                   ms_tick;
   logic                   blink;
   logic                   dot;

   modport ctrl (output mode, output ms_tick, output blink, input dot);
   modport gen  (input mode, input ms_tick, input blink, output dot);
endinterface

// [core/pso_dot_gen.sv]
// One path status dot pattern generator.
// Assumes one-cycle tick and blink strobes.
module pso_dot_gen
(
   input  wire logic i_clk_sys,
   input  wire logic i_rst,
   pso_dot_if.gen    dif
);

   logic [10:0] phase_ff;
   logic [10:0] on_ms;
   logic [10:0] period_ms;
   logic [4:0]  blink_ff;
   logic        base;

   // Pattern lengths per mode
   always_comb
   begin
      on_ms     = 11'h0;
      period_ms = 11'h1;
      case (dif.mode)
         pso_pkg::DOT_SLOW:
         begin
            on_ms     = 11'(pso_pkg::SLOW_ON_MS);
            period_ms = 11'(pso_pkg::SLOW_ON_MS + pso_pkg::SLOW_OFF_MS);
         end
         pso_pkg::DOT_RAPID:
         begin
            on_ms     = 11'(pso_pkg::RAPID_ON_MS);
            period_ms = 11'(pso_pkg::RAPID_ON_MS + pso_pkg::RAPID_OFF_MS);
         end
         pso_pkg::DOT_VOLT:
         begin
            on_ms     = 11'(pso_pkg::VOLT_ON_MS);
            period_ms = 11'(pso_pkg::VOLT_ON_MS + pso_pkg::VOLT_OFF_MS);
         end
         default:
         begin
            on_ms     = 11'h0;
            period_ms = 11'h1;
         end
      endcase
   end

   // Free-running phase; mode change keeps count
   always_ff @(posedge i_clk_sys)
   begin
      if (i_rst)
         phase_ff <= 11'h0;
      else if (dif.ms_tick)
         phase_ff <= (phase_ff + 11'h1 >= period_ms) ? 11'h0 : phase_ff + 11'h1;
   end

   always_ff @(posedge i_clk_sys)
   begin
      if (i_rst)
         blink_ff <= 5'h0;
      else if (dif.blink)
         blink_ff <= 5'(pso_pkg::DATA_BLINK_MS);
      else if (dif.ms_tick && blink_ff != 5'h0)
         blink_ff <= blink_ff - 5'h1;
   end

   // steady, dark or flashing base level
   assign base = (dif.mode == pso_pkg::DOT_ON) ||
                 (dif.mode != pso_pkg::DOT_OFF && phase_ff < on_ms);

   // Blink overrides; prior indication returns
   always_ff @(posedge i_clk_sys)
   begin
      if (i_rst)
         dif.dot <= 1'b0;
      else
         dif.dot <= base && (blink_ff == 5'h0) && !dif.blink;
   end

endmodule

// [core/pso_status_outputs.sv]
// Path status dots, mains-fail delay, path query and general outputs.
// Assumes path and server inputs are on i_clk_sys;
// alarm pins are synchronised here.
module pso_status_outputs
#(
   parameter int unsigned CYC_PER_MS = pso_pkg::CYC_PER_MS
)
(
   input  wire logic       i_clk_sys,
   input  wire logic       i_rst,
   input  wire logic       i_pin_alarm_one,
   input  wire logic       i_pin_return_trig,
   input  wire logic       i_pin_path_query,
   input  wire logic       i_pin_mains_fail,
   input  wire logic [2:0] i_fail_output_mode_select,
   input  wire logic [2:0] i_mains_delay_min,
   input  wire logic       i_query_invert,
   input  wire logic       i_rps_invert,
   input  wire logic       i_fire_mode,
   input  wire logic       i_wire_is_pstn,
   input  wire logic [1:0] i_ip_state,
   input  wire logic [1:0] i_wl_state,
   input  wire logic       i_ip_traffic,
   input  wire logic       i_wl_traffic,
   input  wire logic       i_pstn_dialling,
   input  wire logic       i_pstn_in_call,
   input  wire logic       i_pstn_last_ok,
   input  wire logic       i_pstn_volt_fail,
   input  wire logic       i_wire_fail,
   input  wire logic       i_wl_fail,
   input  wire logic       i_telem_valid,
   input  wire logic       i_telem_id,
   input  wire logic [7:0] i_telem_data,
   input  wire logic       i_alarm_one_sent,
   input  wire logic       i_ack_alarm_one,
   input  wire logic       i_ack_return,
   output logic            o_dot_left,
   output logic            o_dot_right,
   output logic            o_general_output_one,
   output logic            o_general_output_two,
   output logic            o_general_output_three,
   output logic            o_mains_display,
   output logic            o_mains_tx,
   output logic            o_alarm_eleven
);

   localparam int unsigned TW = pso_pkg::TMR_W;

   logic [3:0]    sync1_ff;
   logic [3:0]    sync2_ff;
   logic          alarm1;
   logic          ret_trig;
   logic          query;
   logic          mains;
   logic          ret_prev_ff;
   logic          query_prev_ff;
   logic [15:0]   div_ff;
   logic          tick_ff;
   logic [TW-1:0] wire_tmr_ff;
   logic [TW-1:0] wl_tmr_ff;
   logic          wire_failed_ff;
   logic          wl_failed_ff;
   logic [TW-1:0] wire_limit;
   logic [TW-1:0] query_tmr_ff;
   logic          ctrl_ff;
   logic [TW-1:0] noack_tmr_ff;
   logic          noack_run_ff;
   logic          noack_ff;
   logic          ack_ff;
   logic          rps_ff;
   logic          rps_ack_ff;
   logic [TW-1:0] rps_tmr_ff;
   logic [TW-1:0] mains_tmr_ff;
   logic [2:0]    mains_min_ff;
   logic          mains_tx_ff;
   logic          out1_ff;
   logic          out2_ff;
   logic          out3_ff;
   logic [1:0]    dot_ff;
   logic          nxt_out1;
   logic          nxt_out2;
   logic          nxt_out3;
   logic          query_mode;

   pso_pkg::pso_dot_mode_t dot_mode [2];
   logic                   dot_blink [2];

   // Pin synchronisers
   always_ff @(posedge i_clk_sys)
   begin
      if (i_rst)
      begin
         sync1_ff <= 4'h0;
         sync2_ff <= 4'h0;
      end
      else
      begin
         sync1_ff <= {i_pin_mains_fail, i_pin_path_query, i_pin_return_trig, i_pin_alarm_one};
         sync2_ff <= sync1_ff;
      end
   end

   assign alarm1   = sync2_ff[0];
   assign ret_trig = sync2_ff[1];
   // learned polarity of the query input
   assign query    = sync2_ff[2] ^ i_query_invert;
   assign mains    = sync2_ff[3];

   always_ff @(posedge i_clk_sys)
   begin
      if (i_rst)
      begin
         div_ff  <= 16'h0;
         tick_ff <= 1'b0;
      end
      else
      begin
         tick_ff <= (div_ff == 16'(CYC_PER_MS - 1));
         div_ff  <= (div_ff == 16'(CYC_PER_MS - 1)) ? 16'h0 : div_ff + 16'h1;
      end
   end

   // Edge history for triggers
   always_ff @(posedge i_clk_sys)
   begin
      if (i_rst)
      begin
         ret_prev_ff   <= 1'b0;
         // Match the cleared synchroniser, so no false toggle
         query_prev_ff <= i_query_invert;
      end
      else
      begin
         ret_prev_ff   <= ret_trig;
         query_prev_ff <= query;
      end
   end

   // path fail debounce; one wireline timer
   assign wire_limit = i_wire_is_pstn ? pso_pkg::PSTN_FAIL_TICKS : pso_pkg::IP_FAIL_TICKS;

   always_ff @(posedge i_clk_sys)
   begin
      if (i_rst || !i_wire_fail)
      begin
         wire_tmr_ff    <= '0;
         wire_failed_ff <= 1'b0;
      end
      else if (tick_ff && !wire_failed_ff)
      begin
         wire_tmr_ff    <= wire_tmr_ff + TW'(1);
         wire_failed_ff <= (wire_tmr_ff + TW'(1) >= wire_limit);
      end
   end

   always_ff @(posedge i_clk_sys)
   begin
      if (i_rst || !i_wl_fail)
      begin
         wl_tmr_ff    <= '0;
         wl_failed_ff <= 1'b0;
      end
      else if (tick_ff && !wl_failed_ff)
      begin
         wl_tmr_ff    <= wl_tmr_ff + TW'(1);
         wl_failed_ff <= (wl_tmr_ff + TW'(1) >= pso_pkg::WL_FAIL_TICKS);
      end
   end

   // query function only in mode 1
   assign query_mode = (i_fail_output_mode_select == pso_pkg::FMODE_QUERY);

   // query toggle on single failure pulses low
   always_ff @(posedge i_clk_sys)
   begin
      if (i_rst)
         query_tmr_ff <= '0;
      else if (query_mode && (query != query_prev_ff) && (wire_failed_ff ^ wl_failed_ff))
         query_tmr_ff <= pso_pkg::QUERY_TICKS;
      else if (tick_ff && query_tmr_ff != '0)
         query_tmr_ff <= query_tmr_ff - TW'(1);
   end

   always_ff @(posedge i_clk_sys)
   begin
      if (i_rst)
         ctrl_ff <= 1'b1;
      else if (i_telem_valid && i_telem_data == pso_pkg::TELEM_DATA_SET)
         ctrl_ff <= (i_telem_id == pso_pkg::TELEM_ID_HIGH);
   end

   always_ff @(posedge i_clk_sys)
   begin
      if (i_rst)
      begin
         noack_run_ff <= 1'b0;
         noack_tmr_ff <= '0;
         noack_ff     <= 1'b0;
      end
      else if (i_alarm_one_sent)
      begin
         noack_run_ff <= 1'b1;
         noack_tmr_ff <= '0;
      end
      else if (i_ack_alarm_one)
      begin
         noack_run_ff <= 1'b0;
         noack_ff     <= 1'b0;
      end
      else if (noack_run_ff && tick_ff)
      begin
         noack_tmr_ff <= noack_tmr_ff + TW'(1);
         if (noack_tmr_ff + TW'(1) >= pso_pkg::NOACK_TICKS)
         begin
            noack_ff     <= 1'b1;
            noack_run_ff <= 1'b0;
         end
      end
      else if (!alarm1)
         noack_ff <= 1'b0;
   end

   // acknowledge latch; a new ack wins over input 1 reset
   always_ff @(posedge i_clk_sys)
   begin
      if (i_rst)
         ack_ff <= 1'b0;
      else if (i_ack_alarm_one)
         ack_ff <= 1'b1;
      else if (!alarm1)
         ack_ff <= 1'b0;
   end

   // return path, 1 s minimum hold
   always_ff @(posedge i_clk_sys)
   begin
      if (i_rst)
      begin
         rps_ff     <= 1'b0;
         rps_ack_ff <= 1'b0;
         rps_tmr_ff <= '0;
      end
      else if (ret_trig && !ret_prev_ff)
      begin
         rps_ff     <= 1'b1;
         rps_ack_ff <= 1'b0;
         rps_tmr_ff <= pso_pkg::RPS_MIN_TICKS;
      end
      else if (rps_ff)
      begin
         if (tick_ff && rps_tmr_ff != '0)
            rps_tmr_ff <= rps_tmr_ff - TW'(1);
         // Early ack held until hold expires
         if (i_ack_return)
            rps_ack_ff <= 1'b1;
         if ((rps_ack_ff || i_ack_return) && rps_tmr_ff == '0)
            rps_ff <= 1'b0;
      end
   end

   always_ff @(posedge i_clk_sys)
   begin
      if (i_rst)
      begin
         mains_tx_ff  <= 1'b0;
         mains_tmr_ff <= '0;
         mains_min_ff <= pso_pkg::MAINS_DELAY_RST;
      end
      else if (mains == mains_tx_ff)
      begin
         mains_tmr_ff <= '0;
         mains_min_ff <= i_mains_delay_min;
      end
      else if (mains_min_ff == 3'h0)
         mains_tx_ff <= mains;
      else if (tick_ff)
      begin
         if (mains_tmr_ff + TW'(1) >= pso_pkg::MIN_TICKS)
         begin
            mains_tmr_ff <= '0;
            mains_min_ff <= mains_min_ff - 3'h1;
         end
         else
            mains_tmr_ff <= mains_tmr_ff + TW'(1);
      end
   end

   // Output selection by mode
   always_comb
   begin
      nxt_out1 = wire_failed_ff || wl_failed_ff;
      nxt_out2 = i_fire_mode ? noack_ff : ctrl_ff;
      nxt_out3 = i_fire_mode ? ack_ff : (rps_ff ^ i_rps_invert);
      case (i_fail_output_mode_select)
         // line fault output, low on failure
         pso_pkg::FMODE_LINE:
            nxt_out1 = !(wire_failed_ff || wl_failed_ff);
         pso_pkg::FMODE_SPLIT:
         begin
            nxt_out1 = wire_failed_ff;
            nxt_out2 = wl_failed_ff;
         end
         // high on any failure, low pulse on query
         default:
            nxt_out1 = (wire_failed_ff || wl_failed_ff) && (query_tmr_ff == '0);
      endcase
   end

   always_comb
   begin
      dot_mode[1]  = (i_wl_state == pso_pkg::PATH_UP) ? pso_pkg::DOT_ON :
                     (i_wl_state == pso_pkg::PATH_ADDRESS) ? pso_pkg::DOT_SLOW :
                     pso_pkg::DOT_OFF;
      dot_blink[1] = i_wl_traffic;
      dot_blink[0] = i_ip_traffic && !i_wire_is_pstn;
      if (!i_wire_is_pstn)
         dot_mode[0] = (i_ip_state == pso_pkg::PATH_UP) ? pso_pkg::DOT_ON :
                       (i_ip_state == pso_pkg::PATH_ADDRESS) ? pso_pkg::DOT_SLOW :
                       pso_pkg::DOT_OFF;
      // voltage fail first, then call states
      else if (i_pstn_volt_fail)
         dot_mode[0] = pso_pkg::DOT_VOLT;
      else if (i_pstn_in_call)
         dot_mode[0] = pso_pkg::DOT_RAPID;
      else if (i_pstn_dialling)
         dot_mode[0] = pso_pkg::DOT_SLOW;
      else
         dot_mode[0] = i_pstn_last_ok ? pso_pkg::DOT_ON : pso_pkg::DOT_OFF;
   end

   // One pattern generator per dot
   for (genvar g = 0; g < 2; g++)
   begin : g_dot
      pso_dot_if dif ();

      assign dif.mode    = dot_mode[g];
      assign dif.ms_tick = tick_ff;
      assign dif.blink   = dot_blink[g];

      pso_dot_gen u_gen
      (
         .i_clk_sys (i_clk_sys),
         .i_rst     (i_rst),
         .dif       (dif)
      );

      always_ff @(posedge i_clk_sys)
      begin
         if (i_rst)
            dot_ff[g] <= 1'b0;
         else
            dot_ff[g] <= dif.dot;
      end
   end

   always_ff @(posedge i_clk_sys)
   begin
      if (i_rst)
      begin
         out1_ff         <= 1'b0;
         out2_ff         <= 1'b1;
         out3_ff         <= 1'b0;
         o_mains_display <= 1'b0;
         o_mains_tx      <= 1'b0;
         o_alarm_eleven  <= 1'b0;
      end
      else
      begin
         out1_ff         <= nxt_out1;
         out2_ff         <= nxt_out2;
         out3_ff         <= nxt_out3;
         o_mains_display <= mains;
         o_mains_tx      <= mains_tx_ff;
         o_alarm_eleven  <= query_mode ? 1'b0 : query;
      end
   end

   assign o_general_output_one   = out1_ff;
   assign o_general_output_two   = out2_ff;
   assign o_general_output_three = out3_ff;
   assign o_dot_left             = dot_ff[0];
   assign o_dot_right            = dot_ff[1];

endmodule

// [verif/pso_server_model.sv]
// Server model: acknowledges input 1 alarms and input 4 triggers.
// Assumes pulses on i_clk_sys.
module pso_server_model
(
   input  wire logic        i_clk_sys,
   input  wire logic        i_rst,
   input  wire logic        i_sent,
   input  wire logic        i_trig,
   input  wire logic        i_ack_en,
   input  wire logic [15:0] i_ack_dly,
   output logic             o_ack_one,
   output logic             o_ack_ret
);
   logic [15:0] one_ff;
   logic [15:0] ret_ff;
   logic        trig_ff;
   // Alarm ack countdown; a disabled ack models a lost reply
   // ack or silence
   always_ff @(posedge i_clk_sys)
   begin
      if (i_rst)
         one_ff <= 16'h0;
      else if (i_sent && i_ack_en)
         one_ff <= i_ack_dly;
      else if (one_ff != 16'h0)
         one_ff <= one_ff - 16'h1;
   end
   // Return path ack from input 4 rise
   // server acknowledge
   always_ff @(posedge i_clk_sys)
   begin
      trig_ff <= i_trig;
      if (i_rst)
         ret_ff <= 16'h0;
      else if (i_trig && !trig_ff)
         ret_ff <= i_ack_dly;
      else if (ret_ff != 16'h0)
         ret_ff <= ret_ff - 16'h1;
   end
   // Pulse as a count ends
   assign o_ack_one = one_ff == 16'h1;
   assign o_ack_ret = ret_ff == 16'h1;
endmodule

// [verif/pso_status_outputs_asserts.sv]
// Checker on the status output ports, bound to each instance.
// Assumes one clock domain with synchronous active high reset.
module pso_status_outputs_asserts
#(
   parameter int unsigned CYC_PER_MS = 10
)
(
   input wire logic       i_clk_sys,
   input wire logic       i_rst,
   input wire logic       i_pin_mains_fail,
   input wire logic [2:0] i_fail_output_mode_select,
   input wire logic       i_rps_invert,
   input wire logic       i_fire_mode,
   input wire logic       i_wire_fail,
   input wire logic       i_wl_fail,
   input wire logic       i_wl_traffic,
   input wire logic       i_telem_valid,
   input wire logic       i_telem_id,
   input wire logic [7:0] i_telem_data,
   input wire logic       o_dot_left,
   input wire logic       o_dot_right,
   input wire logic       o_general_output_one,
   input wire logic       o_general_output_two,
   input wire logic       o_general_output_three,
   input wire logic       o_mains_display,
   input wire logic       o_mains_tx,
   input wire logic       o_alarm_eleven
);
   localparam int unsigned RPS_MIN = 999 * CYC_PER_MS;
   logic        tel;
   logic        ok;
   logic [19:0] hi_cnt_ff;
   default clocking @(posedge i_clk_sys);
   endclocking
   default disable iff (i_rst);
   // Telemetry live outside split and fire modes
   assign tel = i_telem_valid && i_telem_data == 8'h01 && !i_fire_mode
      && i_fail_output_mode_select != 3'h4;
   assign ok = !i_wire_fail && !i_wl_fail;
   // High time of output 3; one tick of slack for tick phase
   always_ff @(posedge i_clk_sys)
   begin
      if (i_rst || !o_general_output_three)
         hi_cnt_ff <= 20'h0;
      else
         hi_cnt_ff <= hi_cnt_ff + 20'h1;
   end
   a_reset_idle: assert property ($past(i_rst) |->
      !o_dot_left && !o_dot_right && !o_general_output_one && o_general_output_two
      && !o_general_output_three && !o_mains_display && !o_mains_tx && !o_alarm_eleven)
      else $error("not idle");
   a_telem_low: assert property (tel && !i_telem_id |-> ##[1:2] !o_general_output_two)
      else $error("out2 not low");
   a_telem_high: assert property (tel && i_telem_id |-> ##[1:2] o_general_output_two)
      else $error("out2 not high");
   a_mains_shown: assert property ($changed(i_pin_mains_fail) |->
      ##[3:4] o_mains_display == $past(i_pin_mains_fail, 3))
      else $error("display late");
   a_mains_tx_src: assert property ($changed(o_mains_tx) |->
      o_mains_tx == $past(o_mains_display))
      else $error("tx not display");
   a_rps_min_hold: assert property ($fell(o_general_output_three) && !i_rps_invert
      && !i_fire_mode |-> hi_cnt_ff >= RPS_MIN)
      else $error("rps too short");
   a_data_blank: assert property (i_wl_traffic |-> ##4 (!o_dot_right) [*8])
      else $error("no data blink");
   a_line_fault: assert property ((i_fail_output_mode_select == 3'h2 && ok) [*4]
      |-> o_general_output_one)
      else $error("line fault low");
   a_split_fail: assert property ((i_fail_output_mode_select == 3'h4 && ok) [*4]
      |-> !o_general_output_one && !o_general_output_two)
      else $error("split set");
   a_query_gate: assert property ((i_fail_output_mode_select == 3'h1) [*2]
      |-> !o_alarm_eleven)
      else $error("input 11 passed");
endmodule
bind pso_status_outputs pso_status_outputs_asserts #(.CYC_PER_MS(CYC_PER_MS))
   pso_status_outputs_asserts_inst (.*);

// [verif/tb.sv]
// Self-checking bench for the status output block.
// Assumes a one-cycle millisecond tick.
module tb;
   timeunit 1ns;
   timeprecision 1ns;
   localparam int W = 2000;
   logic i_clk_sys = 1'b0, i_rst = 1'b1, i_pin_alarm_one = 1'b0, i_pin_return_trig = 1'b0;
   logic i_pin_path_query = 1'b0, i_pin_mains_fail = 1'b0, i_query_invert = 1'b0;
   logic i_rps_invert = 1'b0, i_fire_mode = 1'b0, i_wire_is_pstn = 1'b0, i_ip_traffic = 1'b0;
   logic i_wl_traffic = 1'b0, i_pstn_dialling = 1'b0, i_pstn_in_call = 1'b0;
   logic i_pstn_last_ok = 1'b0, i_pstn_volt_fail = 1'b0, i_wire_fail = 1'b0, i_wl_fail = 1'b0;
   logic i_telem_valid = 1'b0, i_telem_id = 1'b0, i_alarm_one_sent = 1'b0, ack_en = 1'b1;
   logic [2:0] i_fail_output_mode_select = 3'h1, i_mains_delay_min = 3'h0;
   logic [1:0] i_ip_state = 2'h0, i_wl_state = 2'h0;
   logic [7:0] i_telem_data = 8'h00;
   logic [15:0] ack_dly = 16'h000A;
   logic i_ack_alarm_one, i_ack_return, o_dot_left, o_dot_right, o_general_output_one;
   logic o_general_output_two, o_general_output_three, o_mains_display, o_mains_tx;
   logic o_alarm_eleven;
   int   err_count = 0, total_checks = 0;
   // Tick of one cycle keeps the 80 s wait inside the run budget
   pso_status_outputs #(.CYC_PER_MS(1)) pso_status_outputs_inst (.*);
   pso_server_model pso_server_model_inst (.i_clk_sys(i_clk_sys), .i_rst(i_rst),
      .i_sent(i_alarm_one_sent), .i_trig(i_pin_return_trig), .i_ack_en(ack_en),
      .i_ack_dly(ack_dly), .o_ack_one(i_ack_alarm_one), .o_ack_ret(i_ack_return));
   // 10 MHz clock
   always #50 i_clk_sys = ~i_clk_sys;
   // n edges, then drive delay
   task automatic tk(input int n);
      repeat (n) @(posedge i_clk_sys);
      #10;
   endtask
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      total_checks++;
      if (got !== exp)
      begin
         err_count++;
         $display("wrong value at %0t: %h vs %h", $time, got, exp);
      end
   endtask
   task automatic near(input int got, input int exp, input int tol);
      total_checks++;
      if (got > exp + tol || got < exp - tol)
      begin
         err_count++;
         $display("wrong value at %0t: %h vs %h", $time, got, exp);
      end
   endtask
   task automatic results;
      if (err_count == 0 && total_checks > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   function automatic logic obs(input int k);
      case (k)
         0: return o_dot_left;
         1: return o_dot_right;
         3: return o_general_output_two;
         4: return o_general_output_three;
         5: return o_mains_display;
         default: return o_mains_tx;
      endcase
   endfunction
   // Bounded wait; running out ends the run
   task automatic wt(input int k, input logic v, input int lim, output int n);
      n = 0;
      while (obs(k) !== v)
      begin
         if (n >= lim)
         begin
            chk(obs(k), v);
            results();
         end
         tk(1);
         n++;
      end
   endtask
   // Lit cycles and rises over W cycles
   task automatic meas(output int lit[2], output int rise[2]);
      logic p[2];
      p = '{obs(0), obs(1)};
      lit = '{0, 0};
      rise = '{0, 0};
      repeat (W)
      begin
         tk(1);
         for (int k = 0; k < 2; k++)
         begin
            lit[k] += (obs(k) === 1'b1);
            rise[k] += (obs(k) === 1'b1 && p[k] !== 1'b1);
            p[k] = obs(k);
         end
      end
   endtask
   // Expected counts per dot mode
   function automatic void pat(input int m, output int lit, output int rise);
      int on[5] = '{0, 1, pso_pkg::SLOW_ON_MS, pso_pkg::RAPID_ON_MS, pso_pkg::VOLT_ON_MS};
      int pr[5] = '{1, 1, pso_pkg::SLOW_ON_MS + pso_pkg::SLOW_OFF_MS,
         pso_pkg::RAPID_ON_MS + pso_pkg::RAPID_OFF_MS, pso_pkg::VOLT_ON_MS + pso_pkg::VOLT_OFF_MS};
      lit = W * on[m] / pr[m];
      rise = (m > 1) ? W / pr[m] : 0;
   endfunction
   // Left dot mode in PSTN from {volt, call, dial, last ok}
   function automatic int pstn(input logic [3:0] c);
      return c[3] ? 4 : c[2] ? 3 : c[1] ? 2 : c[0] ? 1 : 0;
   endfunction
   function automatic logic [7:0] lfsr(input logic [7:0] s);
      return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
   endfunction
   initial
   begin
      int lit[2], rise[2], el, er, n;
      logic [7:0] r;
      logic e2;
      logic [3:0] cs[6] = '{4'h0, 4'h1, 4'h2, 4'h4, 4'h8, 4'hE};
      int dl[2] = '{1500, 10};
      r = 8'h24;
      e2 = 1'b1;
      tk(3);
      chk({o_dot_left, o_dot_right, o_general_output_one, o_general_output_two,
         o_general_output_three, o_mains_display, o_mains_tx, o_alarm_eleven}, 8'h10);
      i_rst = 1'b0;
      for (int s = 0; s < 3; s++)
      begin
         i_ip_state = 2'(s);
         i_wl_state = 2'(2 - s);
         tk(4);
         meas(lit, rise);
         pat(s == 1 ? 2 : s / 2, el, er);
         near(lit[0], el, 10);
         near(rise[0], er, 1);
         pat(s == 1 ? 2 : 1 - s / 2, el, er);
         near(lit[1], el, 10);
         near(rise[1], er, 1);
      end
      i_wl_state = 2'h2;
      tk(4);
      for (int k = 0; k < 2; k++)
      begin
         i_ip_traffic = (k == 0);
         i_wl_traffic = (k == 1);
         tk(1);
         i_ip_traffic = 1'b0;
         i_wl_traffic = 1'b0;
         wt(k, 1'b0, 6, n);
         wt(k, 1'b1, 40, n);
         near(n, pso_pkg::DATA_BLINK_MS, 2);
      end
      i_wire_is_pstn = 1'b1;
      foreach (cs[i])
      begin
         {i_pstn_volt_fail, i_pstn_in_call, i_pstn_dialling, i_pstn_last_ok} = cs[i];
         tk(4);
         meas(lit, rise);
         pat(pstn(cs[i]), el, er);
         near(lit[0], el, 10);
         near(rise[0], er, 1);
      end
      for (int i = 0; i < 12; i++)
      begin
         r = lfsr(r);
         i_telem_id = r[0];
         i_telem_data = r[1] ? pso_pkg::TELEM_DATA_SET : r;
         i_telem_valid = 1'b1;
         tk(1);
         i_telem_valid = 1'b0;
         e2 = (i_telem_data == pso_pkg::TELEM_DATA_SET) ? i_telem_id : e2;
         tk(3);
         chk(o_general_output_two, e2);
      end
      i_fail_output_mode_select = 3'h2;
      i_pin_path_query = 1'b1;
      tk(6);
      chk({o_general_output_one, o_alarm_eleven}, 8'h3);
      i_query_invert = 1'b1;
      i_wire_fail = 1'b1;
      tk(6);
      chk({o_general_output_one, o_alarm_eleven}, 8'h2);
      i_wire_fail = 1'b0;
      i_fail_output_mode_select = 3'h4;
      tk(6);
      chk({o_general_output_one, o_general_output_two}, 8'h0);
      i_fail_output_mode_select = 3'h1;
      tk(6);
      chk({o_general_output_one, o_alarm_eleven}, 8'h0);
      i_pin_mains_fail = 1'b1;
      wt(5, 1'b1, 5, n);
      wt(6, 1'b1, 3, n);
      chk(o_mains_tx, 1'b1);
      i_mains_delay_min = 3'h1;
      i_pin_mains_fail = 1'b0;
      wt(5, 1'b0, 5, n);
      tk(500);
      chk({o_mains_display, o_mains_tx}, 8'h1);
      foreach (dl[i])
      begin
         ack_dly = 16'(dl[i]);
         i_pin_return_trig = 1'b1;
         wt(4, 1'b1, 6, n);
         wt(4, 1'b0, 3000, n);
         near(n, dl[i] > 1000 ? dl[i] : 1000, 8);
         i_pin_return_trig = 1'b0;
         tk(4);
      end
      i_rps_invert = 1'b1;
      tk(3);
      chk(o_general_output_three, 1'b1);
      i_pin_return_trig = 1'b1;
      wt(4, 1'b0, 6, n);
      wt(4, 1'b1, 3000, n);
      near(n, 1000, 8);
      i_pin_return_trig = 1'b0;
      i_rps_invert = 1'b0;
      i_fire_mode = 1'b1;
      i_fail_output_mode_select = 3'h2;
      ack_dly = 16'h0014;
      for (int f = 0; f < 2; f++)
      begin
         ack_en = (f == 0);
         i_pin_alarm_one = 1'b1;
         tk(4);
         i_alarm_one_sent = 1'b1;
         tk(1);
         i_alarm_one_sent = 1'b0;
         wt(4 - f, 1'b1, f ? 80010 : 40, n);
         near(n, f ? pso_pkg::NOACK_S * pso_pkg::MS_PER_S : 21, 4);
         i_pin_alarm_one = 1'b0;
         tk(6);
         chk(obs(4 - f), 1'b0);
      end
      results();
   end
endmodule
